// ---- hdl/bst_defs.svh ----
/*
 * constants of the boundary-scan test port: lengths, field positions,
 * instruction codes and the instruction capture value.
 * assumes it is included by its bare name before any use.
 */
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH

// ****************************************
// lengths
// ****************************************
`define BST_IR_LEN      10
`define BST_CELL_BITS   3
`define BST_NUM_CELLS   8

// ****************************************
// bit positions inside one boundary cell
// ****************************************
`define BST_CELL_IN     0
`define BST_CELL_OE     1
`define BST_CELL_OUT    2

// ****************************************
// instruction codes, all ones is bypass
// ****************************************
`define BST_OP_EXTEST   10'h000
`define BST_OP_SAMPLE   10'h005
`define BST_OP_CLAMP    10'h00a
`define BST_OP_HIGHZ    10'h00b
`define BST_OP_BYPASS   10'h3ff
`define BST_IR_CAPTURE  10'h001

`endif

// ---- hdl/bst_pkg.sv ----
/*
 * types of the boundary-scan test port: tap states, the bundle of
 * sampled test pins and the tap next-state function.
 * assumes nothing of its surroundings.
 */
package bst_pkg;

   // ****************************************
   // tap controller states, one-hot
   // ****************************************
   typedef enum logic [15:0] {
      BST_TLR    = 16'h0001,
      BST_RTI    = 16'h0002,
      BST_SEL_DR = 16'h0004,
      BST_CAP_DR = 16'h0008,
      BST_SH_DR  = 16'h0010,
      BST_EX1_DR = 16'h0020,
      BST_PA_DR  = 16'h0040,
      BST_EX2_DR = 16'h0080,
      BST_UPD_DR = 16'h0100,
      BST_SEL_IR = 16'h0200,
      BST_CAP_IR = 16'h0400,
      BST_SH_IR  = 16'h0800,
      BST_EX1_IR = 16'h1000,
      BST_PA_IR  = 16'h2000,
      BST_EX2_IR = 16'h4000,
      BST_UPD_IR = 16'h8000
   } bst_state_t;

   // test pins that travel together through the synchroniser
   typedef struct packed {
      logic tck;   // test clock
      logic tms;   // mode select
      logic tdi;   // serial data in
   } bst_jtag_t;

   // standard sixteen-state walk, stepped by mode select
   function automatic bst_state_t bst_next_state(bst_state_t s, logic tms);
      bst_state_t r;
      r = BST_TLR;
      case (s)
         BST_TLR    : r = tms ? BST_TLR    : BST_RTI;
         BST_RTI    : r = tms ? BST_SEL_DR : BST_RTI;
         BST_SEL_DR : r = tms ? BST_SEL_IR : BST_CAP_DR;
         BST_CAP_DR : r = tms ? BST_EX1_DR : BST_SH_DR;
         BST_SH_DR  : r = tms ? BST_EX1_DR : BST_SH_DR;
         BST_EX1_DR : r = tms ? BST_UPD_DR : BST_PA_DR;
         BST_PA_DR  : r = tms ? BST_EX2_DR : BST_PA_DR;
         BST_EX2_DR : r = tms ? BST_UPD_DR : BST_SH_DR;
         BST_UPD_DR : r = tms ? BST_SEL_DR : BST_RTI;
         BST_SEL_IR : r = tms ? BST_TLR    : BST_CAP_IR;
         BST_CAP_IR : r = tms ? BST_EX1_IR : BST_SH_IR;
         BST_SH_IR  : r = tms ? BST_EX1_IR : BST_SH_IR;
         BST_EX1_IR : r = tms ? BST_UPD_IR : BST_PA_IR;
         BST_PA_IR  : r = tms ? BST_EX2_IR : BST_PA_IR;
         BST_EX2_IR : r = tms ? BST_UPD_IR : BST_SH_IR;
         BST_UPD_IR : r = tms ? BST_SEL_DR : BST_RTI;
         default    : r = BST_TLR;
      endcase
      return r;
   endfunction

endpackage

// ---- hdl/bst_skid_buf.sv ----
/*
 * two-entry buffer with valid and ready on both sides.
 * assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module bst_skid_buf #(
   parameter int W = 10
) (
   input  wire  logic         ref_clk,
   input  wire  logic         rst_n,
   input  wire  logic [W-1:0] in_data,
   input  wire  logic         in_valid,
   output logic               in_ready,
   output logic [W-1:0]       out_data,
   output logic               out_valid,
   input  wire  logic         out_ready
);
   import bst_pkg::*;

   // ****************************************
   // state: output stage plus one skid entry
   // ****************************************
   typedef struct packed {
      logic [W-1:0] out;     // head word, drives the output
      logic         out_v;   // head word valid
      logic [W-1:0] skid;    // second word while head is stalled
      logic         skid_v;  // second word valid
   } bst_buf_t;

   bst_buf_t buf_reg;
   bst_buf_t buf_next;
   logic     take;           // word accepted on the filling side

   // accept while the skid entry is free; ready is a flop, never a loop
   always_comb begin
      buf_next = buf_reg;
      take     = in_valid & ~buf_reg.skid_v;
      if (out_ready | ~buf_reg.out_v) begin
         // head drains or is empty: refill from skid first, keeps order
         if (buf_reg.skid_v) begin
            buf_next.out    = buf_reg.skid;
            buf_next.out_v  = 1'b1;
            buf_next.skid_v = take;
            buf_next.skid   = in_data;
         end else begin
            buf_next.out   = take ? in_data : buf_reg.out;
            buf_next.out_v = take;
         end
      end else if (take) begin
         // head stalled: park the word
         buf_next.skid   = in_data;
         buf_next.skid_v = 1'b1;
      end
   end

   // register the whole state
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_reg <= '0;
      end else begin
         buf_reg <= buf_next;
      end
   end

   assign in_ready  = ~buf_reg.skid_v;
   assign out_data  = buf_reg.out;
   assign out_valid = buf_reg.out_v;

endmodule

`default_nettype wire

// ---- hdl/bst_tap_top.sv ----
/*
 * boundary-scan test access port: tap controller, instruction register,
 * bypass bit and boundary chain of three-bit cells, all running on
 * ref_clk, which oversamples the test clock and finds its edges.
 * assumes the test clock is far slower than ref_clk (at least eight
 * ref_clk periods per half cycle) and that core signals share ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bst_defs.svh"

// What this block does
// - sample data in on test clock rise
// - change data out on test clock fall
// - data out floats unless shifting
// - states step on rising edge only
// - test reset low resets asynchronously
// - four pins suffice, test reset optional
// - instruction selects operation and register
// - one-bit bypass is shortest path
// - boundary register is one long chain
// - three chain bits per pin
// - pins float while configuring over port
// - instruction shifts in, decode drives registers
// - instruction register is ten bits
// - all-ones instruction selects bypass
// - update stages hold while chain shifts
module bst_tap_top #(
   parameter int N = `BST_NUM_CELLS
) (
   input  wire  logic                  ref_clk,
   input  wire  logic                  nrst,
   input  wire  logic                  trst_n,
   input  wire  bst_pkg::bst_jtag_t    jtag_in,
   output logic                        tdo,
   output logic                        tdo_oe,
   input  wire  logic                  cfg_active,
   input  wire  logic [N-1:0]          core_out,
   input  wire  logic [N-1:0]          core_oe,
   input  wire  logic [N-1:0]          pin_in,
   output logic [N-1:0]                pin_out,
   output logic [N-1:0]                pin_oe,
   output logic [N-1:0]                core_in,
   output logic [`BST_IR_LEN-1:0]      ir_word,
   output logic                        ir_valid,
   input  wire  logic                  ir_ready
);
   import bst_pkg::*;

   localparam int B = N * `BST_CELL_BITS;   // chain length
   localparam int L = `BST_IR_LEN;

   // ****************************************
   // state of the whole port
   // ****************************************
   typedef struct packed {
      bst_state_t  st;       // tap controller state
      bst_jtag_t   j1;       // synchroniser stage one
      bst_jtag_t   j2;       // stage two
      bst_jtag_t   j3;       // stage three
      bst_jtag_t   jf;       // agreed pin levels
      logic [N-1:0] p1;      // pin input stage one
      logic [N-1:0] p2;      // stage two
      logic [N-1:0] p3;      // stage three
      logic [N-1:0] pf;      // agreed pin inputs
      logic [L-1:0] ir_sh;   // instruction shift stage
      logic [L-1:0] ir;      // loaded instruction
      logic         byp;     // bypass bit
      logic [B-1:0] bsr;     // chain capture and shift stages
      logic [B-1:0] upd;     // chain update stages
      logic         tdo;     // serial out level
      logic         tdo_oe;  // serial out driven
      logic [N-1:0] pout;    // pin drive values
      logic [N-1:0] poe;     // pin drive enables
      logic [N-1:0] cin;     // values seen by the core
      logic         pend;    // new instruction waiting for the buffer
   } bst_core_t;

   // reset: test-logic-reset with bypass loaded, pins not driven
   localparam bst_core_t RST = '{st: BST_TLR, ir: `BST_OP_BYPASS, default: '0};

   bst_core_t    core_reg;
   bst_core_t    core_next;
   logic         rst_n;        // either reset
   logic         tck_rise;     // agreed rising test clock edge
   logic         tck_fall;     // agreed falling test clock edge
   logic         bsr_sel;      // boundary chain is the data path
   logic         drive_test;   // pins follow the update stages
   logic         float_pins;   // pins forced off
   logic         in_shift;     // shifting instruction or data
   logic         buf_ready;    // buffer can take the instruction
   logic [B-1:0] cap_vec;      // capture values of every cell
   logic [N-1:0] pout_n;       // next pin values per cell
   logic [N-1:0] poe_n;
   logic [N-1:0] cin_n;

   // test reset acts without the clock; release is not synchronised,
   // so the host should release it with the test clock low
   assign rst_n = nrst & trst_n;

   // ****************************************
   // instruction decode
   // ****************************************
   // unknown codes fall back to bypass
   assign bsr_sel    = (core_reg.ir == `BST_OP_EXTEST) |
                       (core_reg.ir == `BST_OP_SAMPLE);
   assign drive_test = (core_reg.ir == `BST_OP_EXTEST) |
                       (core_reg.ir == `BST_OP_CLAMP);
   assign float_pins = (core_reg.ir == `BST_OP_HIGHZ) | cfg_active;
   assign in_shift   = (core_reg.st == BST_SH_IR) | (core_reg.st == BST_SH_DR);

   // ****************************************
   // per-cell capture and pin muxing
   // ****************************************
   // each cell adds in, oe and out bits to the chain
   for (genvar c = 0; c < N; c++) begin : g_cell
      localparam int O = c * `BST_CELL_BITS;
      assign cap_vec[O + `BST_CELL_IN]  = core_reg.pf[c];
      assign cap_vec[O + `BST_CELL_OE]  = core_oe[c];
      assign cap_vec[O + `BST_CELL_OUT] = core_out[c];
      assign pout_n[c] = drive_test ? core_reg.upd[O + `BST_CELL_OUT] : core_out[c];
      assign poe_n[c]  = float_pins ? 1'b0 :
                         drive_test ? core_reg.upd[O + `BST_CELL_OE] : core_oe[c];
      assign cin_n[c]  = (core_reg.ir == `BST_OP_EXTEST) ?
                         core_reg.upd[O + `BST_CELL_IN] : core_reg.pf[c];
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      core_next = core_reg;
      // three stages, a change counts once stages two and three agree
      core_next.j1 = jtag_in;
      core_next.j2 = core_reg.j1;
      core_next.j3 = core_reg.j2;
      core_next.jf = bst_jtag_t'((core_reg.j2 & ~(core_reg.j2 ^ core_reg.j3)) |
                                 (core_reg.jf & (core_reg.j2 ^ core_reg.j3)));
      core_next.p1 = pin_in;
      core_next.p2 = core_reg.p1;
      core_next.p3 = core_reg.p2;
      core_next.pf = (core_reg.p2 & ~(core_reg.p2 ^ core_reg.p3)) |
                     (core_reg.pf & (core_reg.p2 ^ core_reg.p3));
      tck_rise = core_next.jf.tck & ~core_reg.jf.tck;
      tck_fall = ~core_next.jf.tck & core_reg.jf.tck;
      // the tap only moves on a rising test clock edge
      if (tck_rise) begin
         core_next.st = bst_next_state(core_reg.st, core_next.jf.tms);
         case (core_reg.st)
            BST_CAP_IR : core_next.ir_sh = `BST_IR_CAPTURE;
            // ten-bit shift, lsb leaves first
            BST_SH_IR  : core_next.ir_sh = {core_next.jf.tdi, core_reg.ir_sh[L-1:1]};
            BST_UPD_IR : core_next.ir = core_reg.ir_sh;
            BST_CAP_DR : begin
               core_next.byp = 1'b0;
               if (bsr_sel) begin
                  core_next.bsr = cap_vec;
               end
            end
            BST_SH_DR  : begin
               if (bsr_sel) begin
                  core_next.bsr = {core_next.jf.tdi, core_reg.bsr[B-1:1]};
               end else begin
                  core_next.byp = core_next.jf.tdi;
               end
            end
            // update stages move only here, never while shifting
            BST_UPD_DR : begin
               if (bsr_sel) begin
                  core_next.upd = core_reg.bsr;
               end
            end
            default    : begin
            end
         endcase
      end
      // reset state keeps bypass loaded
      if (core_reg.st == BST_TLR) begin
         core_next.ir = `BST_OP_BYPASS;
      end
      // serial out moves half a cycle after capture
      if (tck_fall) begin
         core_next.tdo_oe = in_shift;
         if (core_reg.st == BST_SH_IR) begin
            core_next.tdo = core_reg.ir_sh[0];
         end else if (bsr_sel) begin
            core_next.tdo = core_reg.bsr[0];
         end else begin
            core_next.tdo = core_reg.byp;
         end
      end
      core_next.pout = pout_n;
      core_next.poe  = poe_n;
      core_next.cin  = cin_n;
      // a new instruction is offered once; set wins over the accept
      core_next.pend = (core_reg.pend & ~buf_ready) |
                       (tck_rise & (core_reg.st == BST_UPD_IR));
   end

   // register the whole state; the test reset alone is enough here
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_reg <= RST;
      end else begin
         core_reg <= core_next;
      end
   end

   // ****************************************
   // instruction stream to the user side
   // ****************************************
   // a second update while one still waits overwrites it
   bst_skid_buf #(.W(L)) u_ir_buf (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .in_data   (core_reg.ir),
      .in_valid  (core_reg.pend),
      .in_ready  (buf_ready),
      .out_data  (ir_word),
      .out_valid (ir_valid),
      .out_ready (ir_ready)
   );

   assign tdo     = core_reg.tdo;
   assign tdo_oe  = core_reg.tdo_oe;
   assign pin_out = core_reg.pout;
   assign pin_oe  = core_reg.poe;
   assign core_in = core_reg.cin;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   chk_tdo_float: assert property (tck_fall && !in_shift |=> !tdo_oe)
      else $error("serial out driven outside shift");
   chk_tdo_fall: assert property (!tck_fall |=> $stable(tdo))
      else $error("serial out moved off a falling edge");
   chk_step_rise: assert property (!tck_rise |=> $stable(core_reg.st))
      else $error("tap moved off a rising edge");
   chk_ir_shift: assert property (tck_rise && core_reg.st == BST_SH_IR |=>
      core_reg.ir_sh[L-1] == $past(core_next.jf.tdi) &&
      core_reg.ir_sh[L-2:0] == $past(core_reg.ir_sh[L-1:1]))
      else $error("instruction shift wrong");
   chk_byp_path: assert property (tck_rise && core_reg.st == BST_SH_DR &&
      core_reg.ir == `BST_OP_BYPASS |=> core_reg.byp == $past(core_next.jf.tdi))
      else $error("bypass bit missed data in");
   chk_upd_hold: assert property (core_reg.st != BST_UPD_DR |=> $stable(core_reg.upd))
      else $error("update stages moved");
   chk_cfg_float: assert property (cfg_active |=> pin_oe == '0)
      else $error("pin driven while configuring");
   // bypass is forced one cycle after the reset state, the pins follow the
   // core one cycle later; a configuration in progress keeps them off
   chk_tlr_bypass: assert property (core_reg.st == BST_TLR ##1 !cfg_active |->
      core_reg.ir == `BST_OP_BYPASS ##1 pin_oe == $past(core_oe))
      else $error("reset state not bypass");
   chk_chain_in: assert property (tck_rise && core_reg.st == BST_SH_DR && bsr_sel |=>
      core_reg.bsr[B-1] == $past(core_next.jf.tdi))
      else $error("chain missed data in");

   cov_ir_load: cover property (tck_rise && core_reg.st == BST_UPD_IR);
   cov_extest: cover property (core_reg.ir == `BST_OP_EXTEST && tck_rise &&
                               core_reg.st == BST_UPD_DR);
   cov_buf_full: cover property (core_reg.pend && !buf_ready);

endmodule

`default_nettype wire

// ---- testbench/bst_host_model.sv ----
/*
 * model of the test host on the far side of the test port: drives the
 * test clock, mode select and serial data in, samples serial data out.
 * assumes the bench ref_clk; the test clock half period is 8 ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module bst_host_model (
   input  wire logic ref_clk,
   input  wire logic tdo_w,
   output var  logic tck,
   output var  logic tms,
   output var  logic tdi,
   output var  int   edge_err
);
   // test clock stands low between frames, inputs at pull-up level
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      edge_err = 0;
   end

   // ****************************************
   // one test clock period
   // ****************************************
   // mode select and data settle seven ref_clk periods before the rise
   task automatic step(input logic m, input logic d, output logic q);
      logic held;
      @(negedge ref_clk);
      tms = m;
      tdi = d;
      repeat (7) @(negedge ref_clk);
      q = tdo_w;
      tck = 1'b1;
      repeat (7) @(negedge ref_clk);
      held = tdo_w;
      // data out may only move after the fall, never while high
      if (held !== q) edge_err++;
      @(negedge ref_clk);
      tck = 1'b0;
   endtask

   // five mode-select highs reach reset from any state, then idle
   task automatic reset_tap();
      logic q;
      repeat (5) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask

   // full scan from idle back to idle, lsb first, n bits at most 64
   task automatic scan(input logic ir, input logic [63:0] din, input int n,
                       output logic [63:0] dout);
      logic q;
      dout = '0;
      step(1'b1, 1'b1, q);
      if (ir) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask
endmodule

`default_nettype wire

// ---- testbench/boundary_scan_tap_bench.sv ----
/*
 * self-checking bench of the boundary-scan test port.
 * assumes the design files and the host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bst_defs.svh"

module boundary_scan_tap_bench;
   import bst_pkg::*;

   localparam logic [23:0] pre_v = 24'h9c_36e1;  // preload pattern

   logic       ref_clk;
   logic       nrst;
   logic       trst_n;
   logic       cfg_active;
   logic [7:0] core_out;
   logic [7:0] core_oe;
   logic [7:0] pin_in;
   logic       ir_ready;
   logic       tdo;
   logic       tdo_oe;
   logic       tdo_w;      // resolved data out wire
   logic [7:0] pin_out;
   logic [7:0] pin_oe;
   logic [7:0] core_in;
   logic [9:0] ir_word;
   logic       ir_valid;
   logic       h_tck;
   logic       h_tms;
   logic       h_tdi;
   bst_jtag_t  jtag;
   int         edge_err;
   int         error_cnt;
   int         num_checks;
   int         cyc;

   assign jtag = {h_tck, h_tms, h_tdi};
   // data out floats whenever the port does not drive it
   assign tdo_w = tdo_oe ? tdo : 1'bz;

   always #2.5 ref_clk = ~ref_clk;

   bst_tap_top u_dut (
      .ref_clk(ref_clk), .nrst(nrst), .trst_n(trst_n), .jtag_in(jtag),
      .tdo(tdo), .tdo_oe(tdo_oe), .cfg_active(cfg_active),
      .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .core_in(core_in),
      .ir_word(ir_word), .ir_valid(ir_valid), .ir_ready(ir_ready)
   );

   bst_host_model u_host (
      .ref_clk(ref_clk), .tdo_w(tdo_w), .tck(h_tck), .tms(h_tms),
      .tdi(h_tdi), .edge_err(edge_err)
   );

   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // chain image captured from pin, enable and output of every cell
   function automatic logic [23:0] cap(logic [7:0] p, logic [7:0] e, logic [7:0] o);
      logic [23:0] r;
      for (int c = 0; c < 8; c++) r[3*c +: 3] = {o[c], e[c], p[c]};
      return r;
   endfunction

   // one field of every cell out of a chain image
   function automatic logic [7:0] fld(logic [23:0] v, int k);
      logic [7:0] r;
      for (int c = 0; c < 8; c++) r[c] = v[3*c+k];
      return r;
   endfunction

   // take one word off the instruction stream with a one-edge ready
   task automatic pop_ir(input logic [9:0] exp);
      int k;
      k = 0;
      while (ir_valid !== 1'b1 && k < 40) begin
         @(negedge ref_clk);
         k++;
      end
      chk({ir_valid, ir_word}, {1'b1, exp});
      ir_ready = 1'b1;
      @(negedge ref_clk);
      ir_ready = 1'b0;
   endtask

   task automatic ld_ir(input logic [9:0] code, input logic pop);
      logic [63:0] d;
      u_host.scan(1'b1, 64'(code), 10, d);
      chk(d[9:0], `BST_IR_CAPTURE);
      if (pop) pop_ir(code);
      repeat (4) @(negedge ref_clk);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      chk(tdo_w, 1'bz);
      chk(pin_out, core_out);
      chk(pin_oe, core_oe);
      chk(core_in, pin_in);
      chk(ir_valid, 1'b0);
      cfg_active = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk(pin_oe, 8'h00);
      cfg_active = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk(pin_oe, core_oe);
   endtask

   task automatic t_bypass();
      logic [63:0] d;
      u_host.reset_tap();
      ld_ir(`BST_OP_BYPASS, 1'b1);
      u_host.scan(1'b0, 64'hb5, 8, d);
      chk(d[7:0], 8'h6a);
      // twenty bits pushed: the first ten fall out behind the capture
      u_host.scan(1'b1, {44'h0, 10'h155, 10'h2a5}, 20, d);
      chk(d[19:0], {10'h2a5, 10'h001});
      pop_ir(10'h155);
      u_host.scan(1'b0, 64'hb5, 8, d);
      chk(d[7:0], 8'h6a);
   endtask

   task automatic t_sample();
      logic [63:0] d;
      ld_ir(`BST_OP_SAMPLE, 1'b1);
      u_host.scan(1'b0, 64'(pre_v), 24, d);
      chk(d[23:0], cap(pin_in, core_oe, core_out));
      chk(pin_out, core_out);
   endtask

   // pins from the preload while only the bypass bit shifts
   task automatic t_clamp();
      logic [63:0] d;
      ld_ir(`BST_OP_CLAMP, 1'b1);
      chk(pin_out, fld(pre_v, 2));
      chk(pin_oe, fld(pre_v, 1));
      u_host.scan(1'b0, 64'h3c, 8, d);
      chk(d[7:0], 8'h78);
      chk(pin_out, fld(pre_v, 2));
   endtask

   task automatic t_highz();
      ld_ir(`BST_OP_HIGHZ, 1'b1);
      chk(pin_oe, 8'h00);
   endtask

   task automatic t_extest();
      logic [63:0] d;
      ld_ir(`BST_OP_EXTEST, 1'b1);
      chk(pin_out, fld(pre_v, 2));
      chk(pin_oe, fld(pre_v, 1));
      chk(core_in, fld(pre_v, 0));
      fork
         u_host.scan(1'b0, 64'h0, 24, d);
         begin
            repeat (200) @(negedge ref_clk);
            chk(pin_out, fld(pre_v, 2));
         end
      join
      repeat (4) @(negedge ref_clk);
      chk(pin_out, 8'h00);
   endtask

   // two words wait while the consumer stalls, then drain in order
   task automatic t_buffer();
      ld_ir(`BST_OP_SAMPLE, 1'b0);
      ld_ir(`BST_OP_HIGHZ, 1'b0);
      pop_ir(`BST_OP_SAMPLE);
      pop_ir(`BST_OP_HIGHZ);
      repeat (4) @(negedge ref_clk);
      chk(ir_valid, 1'b0);
   endtask

   // test reset dropped mid-shift with no clock edge needed
   task automatic t_trst();
      logic [63:0] d;
      ld_ir(`BST_OP_SAMPLE, 1'b1);
      fork
         u_host.scan(1'b1, 64'h0, 10, d);
         begin
            repeat (100) @(negedge ref_clk);
            trst_n = 1'b0;
            #1;
            chk(tdo_oe, 1'b0);
            chk(pin_oe, 8'h00);
         end
      join
      trst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk(pin_oe, core_oe);
      u_host.reset_tap();
      u_host.scan(1'b0, 64'hb5, 8, d);
      chk(d[7:0], 8'h6a);
   endtask

   task automatic end_of_test();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // hang guard, well above the length of all scenarios
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         end_of_test();
      end
   end

   initial begin
      ref_clk = 1'b0;
      nrst = 1'b0;
      trst_n = 1'b1;
      cfg_active = 1'b0;
      core_out = 8'ha5;
      core_oe = 8'h3c;
      pin_in = 8'h5a;
      ir_ready = 1'b0;
      error_cnt = 0;
      num_checks = 0;
      cyc = 0;
      repeat (2) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (6) @(negedge ref_clk);
      t_reset();
      t_bypass();
      t_sample();
      t_clamp();
      t_highz();
      t_extest();
      t_buffer();
      t_trst();
      chk(edge_err, 64'h0);
      trst_n = 1'b0;
      end_of_test();
   end
endmodule

`default_nettype wire
